// file: rtccs_ctrl.v
/*
 * Control, event-flag and integrity-status logic of a clock/calendar
 * peripheral: format and enable register, clear-on-read event flags with
 * the composite request flag, backup-valid status, square-wave gating and
 * the two seasonal daylight-saving jumps.
 * Assumes a multiplexed byte bus whose strobes are synchronous to core_clk
 * and held for at least two clock cycles per phase, time counters that
 * present their user-format bytes and a one-cycle pulse just before each
 * one-second advance, and a divider that supplies the square-wave source
 * and the periodic tick.
 */
`include "rtccs_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module rtccs_ctrl (
	// clock and reset
	input  wire       core_clk,
	input  wire       rst_b,
	// multiplexed host bus
	input  wire       cs_b,
	input  wire       addr_strobe,
	input  wire       data_strobe,
	input  wire       read_not_write,
	input  wire [7:0] ad_in,
	output reg  [7:0] ad_out_r,
	output reg        ad_oe_r,
	// events from the time-keeping side
	input  wire       update_done,
	input  wire       alarm_match,
	input  wire       periodic_tick,
	input  wire       square_src,
	input  wire       backup_ok,
	// time counter view, user format
	input  wire       sec_advance,
	input  wire [7:0] tod_sec,
	input  wire [7:0] tod_min,
	input  wire [7:0] tod_hour,
	input  wire [7:0] tod_dow,
	input  wire [7:0] tod_dom,
	input  wire [7:0] tod_month,
	// controls to the time-keeping side
	output reg        hour_format_select_r,
	output reg        number_format_select_r,
	output reg        transfer_enable_r,
	output reg        dst_load_r,
	output reg  [7:0] dst_hour_r,
	// pins
	output reg        square_wave_out_r,
	output reg        irq_b_r
);

	// bcd to binary when the number format is bcd
	function [6:0] to_bin;
		input [7:0] v;
		input       bin_mode;
		begin
			if (bin_mode)
				to_bin = v[6:0];
			else
				to_bin = v[6:4] * 7'd10 + {3'b000, v[3:0]};
		end
	endfunction

	// hour byte to 0..23, both hour formats
	function [6:0] hour24;
		input [7:0] v;
		input       h24;
		input       bin_mode;
		reg   [6:0] h;
		begin
			h = to_bin({1'b0, v[6:0]}, bin_mode);
			hour24 = h;
			if (!h24) begin
				if (h == 7'd12)
					hour24 = v[7] ? 7'd12 : 7'd0;
				else
					hour24 = v[7] ? h + 7'd12 : h;
			end
		end
	endfunction

	// control register and flags
	reg  [7:0] ctrl_r;
	reg  [7:0] ctrl_nxt;
	reg        uf_r;
	reg        af_r;
	reg        pf_r;
	reg        irq_request_flag_r;
	reg        uf_nxt;
	reg        af_nxt;
	reg        pf_nxt;
	reg        irq_request_flag_nxt;
	reg        valid_r;

	// bus tracking
	reg  [7:0] addr_r;
	reg        as_q_r;
	reg        ds_q_r;
	reg        rd_event_r;

	// seasonal state
	reg        fall_done_r;
	reg        spring_done_r;

	wire       sel      = ~cs_b;
	wire       ds_fall  = ds_q_r & ~data_strobe;
	wire       wr_take  = sel & ds_fall & ~read_not_write;
	wire       rd_take  = sel & ds_fall & read_not_write;
	wire       reading  = sel & data_strobe & read_not_write;

	wire       daylight_saving_enable   = ctrl_r[`RTCCS_DSE_BIT];
	wire       h24   = ctrl_r[`RTCCS_HF_BIT];
	wire       dbin  = ctrl_r[`RTCCS_DF_BIT];
	wire       square_wave_enable  = ctrl_r[`RTCCS_SQUARE_WAVE_ENABLE_BIT];
	wire       update_irq_enable   = ctrl_r[`RTCCS_UIE_BIT];
	wire       alarm_irq_enable   = ctrl_r[`RTCCS_AIE_BIT];
	wire       periodic_irq_enable   = ctrl_r[`RTCCS_PIE_BIT];
	wire       transfer_inhibit   = ctrl_r[`RTCCS_UTI_BIT];

	// decoded counter view
	wire [6:0] hr    = hour24(tod_hour, h24, dbin);
	wire [6:0] mn    = to_bin(tod_min, dbin);
	wire [6:0] sc    = to_bin(tod_sec, dbin);
	wire [6:0] mo    = to_bin(tod_month, dbin);
	wire [6:0] dm    = to_bin(tod_dom, dbin);
	wire [6:0] dw    = to_bin(tod_dow, dbin);
	wire       sunday = (dw == `RTCCS_SUNDAY);
	wire       last_tick = (mn == `RTCCS_LAST_MINSEC)
			&& (sc == `RTCCS_LAST_MINSEC);
	wire       oct_day = (mo == `RTCCS_MONTH_OCT) && sunday
			&& (dm >= `RTCCS_LAST_WEEK_DOM);
	wire       apr_day = (mo == `RTCCS_MONTH_APR) && sunday
			&& (dm <= `RTCCS_FIRST_WEEK_DOM);
	// the jump replaces the advance out of the last second of the hour
	wire       do_fall = daylight_saving_enable && sec_advance && oct_day && last_tick
			&& (hr == `RTCCS_HOUR_FALL) && !fall_done_r;
	wire       do_spring = daylight_saving_enable && sec_advance && apr_day && last_tick
			&& (hr == `RTCCS_HOUR_FALL) && !spring_done_r;

	// control register next value
	always @* begin
		ctrl_nxt = ctrl_r;
		if (wr_take && addr_r == `RTCCS_ADDR_CTRL)
			ctrl_nxt = ad_in;
		// inhibit wins over a write that sets the update enable
		if (ctrl_nxt[`RTCCS_UTI_BIT])
			ctrl_nxt[`RTCCS_UIE_BIT] = 1'b0;
	end

	// event flags: a new event in the clearing cycle survives
	always @* begin
		uf_nxt = (rd_event_r ? 1'b0 : uf_r) | update_done;
		af_nxt = (rd_event_r ? 1'b0 : af_r) | alarm_match;
		pf_nxt = (rd_event_r ? 1'b0 : pf_r) | periodic_tick;
		irq_request_flag_nxt = (rd_event_r ? 1'b0 : irq_request_flag_r)
			| (uf_nxt & ctrl_nxt[`RTCCS_UIE_BIT])
			| (af_nxt & ctrl_nxt[`RTCCS_AIE_BIT])
			| (pf_nxt & ctrl_nxt[`RTCCS_PIE_BIT]);
	end

	// bus strobes and address latch
	always @(posedge core_clk) begin
		if (!rst_b) begin
			addr_r     <= 8'h00;
			as_q_r     <= 1'b0;
			ds_q_r     <= 1'b0;
			rd_event_r <= 1'b0;
		end else begin
			as_q_r <= addr_strobe;
			ds_q_r <= data_strobe;
			// address taken while the strobe is high, held after its fall
			if (sel && addr_strobe)
				addr_r <= ad_in;
			// clear-on-read acts when the read ends, not while data is out
			rd_event_r <= rd_take && (addr_r == `RTCCS_ADDR_EVENT);
		end
	end

	// read data path; location 0a belongs to another block
	always @(posedge core_clk) begin
		if (!rst_b) begin
			ad_out_r <= 8'h00;
			ad_oe_r  <= 1'b0;
		end else begin
			ad_oe_r  <= 1'b0;
			ad_out_r <= 8'h00;
			if (reading) begin
				if (addr_r == `RTCCS_ADDR_CTRL) begin
					ad_oe_r  <= 1'b1;
					ad_out_r <= ctrl_r;
				end else if (addr_r == `RTCCS_ADDR_EVENT) begin
					ad_oe_r  <= 1'b1;
					ad_out_r <= {irq_request_flag_r, pf_r, af_r, uf_r, 4'h0};
				end else if (addr_r == `RTCCS_ADDR_INTEG) begin
					ad_oe_r  <= 1'b1;
					ad_out_r <= {valid_r, 7'h00};
				end
			end
		end
	end

	// registers; event and integrity locations take no writes
	always @(posedge core_clk) begin
		if (!rst_b) begin
			ctrl_r  <= `RTCCS_CTRL_RESET;
			uf_r    <= 1'b0;
			af_r    <= 1'b0;
			pf_r    <= 1'b0;
			irq_request_flag_r  <= 1'b0;
			valid_r <= 1'b0;
		end else begin
			ctrl_r  <= ctrl_nxt;
			uf_r    <= uf_nxt;
			af_r    <= af_nxt;
			pf_r    <= pf_nxt;
			irq_request_flag_r  <= irq_request_flag_nxt;
			valid_r <= backup_ok;
		end
	end

	// seasonal adjustment, one shot per affected day
	always @(posedge core_clk) begin
		if (!rst_b) begin
			fall_done_r   <= 1'b0;
			spring_done_r <= 1'b0;
			dst_load_r    <= 1'b0;
			dst_hour_r    <= 8'h00;
		end else begin
			dst_load_r <= do_fall | do_spring;
			if (do_fall)
				dst_hour_r <= `RTCCS_LOAD_FALL;
			else if (do_spring)
				dst_hour_r <= `RTCCS_LOAD_SPRING;
			if (do_fall)
				fall_done_r <= 1'b1;
			else if (!oct_day || hr >= `RTCCS_HOUR_REARM)
				fall_done_r <= oct_day & fall_done_r &
					(hr < `RTCCS_HOUR_REARM);
			// leaving the day re-arms; the repeated hour stays guarded
			if (!oct_day)
				fall_done_r <= 1'b0;
			if (do_spring)
				spring_done_r <= 1'b1;
			else if (!apr_day)
				spring_done_r <= 1'b0;
		end
	end

	// outputs to the time side and pins
	always @(posedge core_clk) begin
		if (!rst_b) begin
			hour_format_select_r   <= 1'b0;
			number_format_select_r <= 1'b0;
			transfer_enable_r      <= 1'b1;
			square_wave_out_r      <= 1'b0;
			irq_b_r                <= 1'b1;
		end else begin
			hour_format_select_r   <= h24;
			number_format_select_r <= dbin;
			transfer_enable_r      <= ~transfer_inhibit;
			square_wave_out_r      <= square_wave_enable & square_src;
			irq_b_r                <= ~irq_request_flag_nxt;
		end
	end

endmodule

`default_nettype wire

// file: rtccs_regs.vh
/*
 * Constants of the clock/calendar control, event-flag and integrity
 * status block: byte locations, field positions, reset values and the
 * calendar codes used by the seasonal adjustment.
 * Assumes it is included once by bare name from the block's design file.
 */
// What this block does
// - October last Sunday: leave 1:59:59, fall to 1:00:00
// - April first Sunday: leave 1:59:59, jump to 3:00:00
// - Seasonal jumps only while daylight-saving bit set
// - Hour format bit: 1 is 24-hour
// - Number format bit: 1 binary, 0 BCD
// - Square wave driven only when enabled, else low
// - Update event interrupts only with bit 4 set
// - Alarm event interrupts only with bit 5 set
// - Periodic event interrupts only with bit 6 set
// - Inhibit bit stops transfers and clears update enable
// - Update enable cleared whenever inhibit is 1
// - Host writes to event flags are ignored
// - Unused flag and integrity bits read zero
// - Update-ended flag set per cycle, cleared on read
// - Alarm flag set on alarm, cleared on read
// - Periodic flag set per interval, cleared on read
// - Request flag set for enabled pending flag
// - Integrity bit 7 shows backup source valid
// - Registers at 0B to 0D, control fully writable
// - Registers reachable even during an update cycle
`ifndef RTCCS_REGS_VH
`define RTCCS_REGS_VH

// byte locations
`define RTCCS_ADDR_A        8'h0a
`define RTCCS_ADDR_CTRL     8'h0b
`define RTCCS_ADDR_EVENT    8'h0c
`define RTCCS_ADDR_INTEG    8'h0d

// control register fields
`define RTCCS_DSE_BIT       0
`define RTCCS_HF_BIT        1
`define RTCCS_DF_BIT        2
`define RTCCS_SQUARE_WAVE_ENABLE_BIT      3
`define RTCCS_UIE_BIT       4
`define RTCCS_AIE_BIT       5
`define RTCCS_PIE_BIT       6
`define RTCCS_UTI_BIT       7
`define RTCCS_CTRL_RESET    8'h00

// event and integrity fields
`define RTCCS_UF_BIT        4
`define RTCCS_AF_BIT        5
`define RTCCS_PF_BIT        6
`define RTCCS_IRQ_REQUEST_FLAG_BIT      7
`define RTCCS_VALID_BIT     7

// calendar codes, binary
`define RTCCS_MONTH_APR     7'h04
`define RTCCS_MONTH_OCT     7'h0a
`define RTCCS_LAST_WEEK_DOM 7'h19
`define RTCCS_FIRST_WEEK_DOM 7'h07
`define RTCCS_SUNDAY        7'h01
`define RTCCS_HOUR_FALL     7'h01
`define RTCCS_HOUR_SPRING   7'h02
`define RTCCS_HOUR_REARM    7'h03
`define RTCCS_LAST_MINSEC   7'h3b
`define RTCCS_LOAD_FALL     8'h01
`define RTCCS_LOAD_SPRING   8'h03

`endif

// file: rtccs_host.sv
/* host byte-bus master model; moves its lines just after core_clk edges */
`timescale 1ns/1ps
`default_nettype none
module rtccs_host (
	// clock
	input  wire logic       core_clk,
	// multiplexed bus
	output var  logic       cs_b,
	output var  logic       addr_strobe,
	output var  logic       data_strobe,
	output var  logic       read_not_write,
	output var  logic [7:0] ad_in
);
	initial begin
		cs_b = 1'b1;
		addr_strobe = 1'b0;
		data_strobe = 1'b0;
		read_not_write = 1'b1;
		ad_in = 8'h5a;
	end
	// strobes held two edges; released bus shows inverted value, not stale
	task acc(input logic rnw, input logic [7:0] a, input logic [7:0] d);
		cs_b <= 1'b0;
		addr_strobe <= 1'b1;
		ad_in <= a;
		repeat (2) @(posedge core_clk);
		addr_strobe <= 1'b0;
		ad_in <= rnw ? ~a : d;
		read_not_write <= rnw;
		@(posedge core_clk);
		data_strobe <= 1'b1;
		repeat (2) @(posedge core_clk);
		data_strobe <= 1'b0;
		@(posedge core_clk);
		cs_b <= 1'b1;
		ad_in <= ~ad_in;
		@(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// file: rtccs_ctrl_asserts.sv
/* assertions on rtccs_ctrl; sees only its ports, bound below */
`timescale 1ns/1ps
`default_nettype none
module rtccs_ctrl_chk (
	// clock, reset, bus
	input wire logic       core_clk,
	input wire logic       rst_b,
	input wire logic       cs_b,
	input wire logic       addr_strobe,
	input wire logic       read_not_write,
	input wire logic [7:0] ad_in,
	input wire logic [7:0] ad_out_r,
	input wire logic       ad_oe_r,
	// events and pins
	input wire logic       update_done,
	input wire logic       alarm_match,
	input wire logic       periodic_tick,
	input wire logic       square_src,
	input wire logic       backup_ok,
	input wire logic       sec_advance,
	input wire logic       dst_load_r,
	input wire logic [7:0] dst_hour_r,
	input wire logic       square_wave_out_r,
	input wire logic       irq_b_r
);
	logic [7:0] addr_q;
	logic       quiet;
	assign quiet = !(update_done | alarm_match | periodic_tick);
	always @(posedge core_clk) begin
		if (!cs_b && addr_strobe) begin
			addr_q <= ad_in;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence evt_read;
		ad_oe_r && addr_q == 8'h0c && quiet ##1 !ad_oe_r && quiet ##1 quiet;
	endsequence
	AST_IRQ_RELEASE: assert property (evt_read |-> irq_b_r)
		else $error("irq held after read");
	AST_EVT_LOW_ZERO: assert property (ad_oe_r && addr_q == 8'h0c |->
		ad_out_r[3:0] == 4'h0) else $error("event low bits");
	AST_INTEG: assert property (ad_oe_r && addr_q == 8'h0d |->
		ad_out_r == {$past(backup_ok, 2), 7'h00}) else $error("integ");
	AST_MAP: assert property (ad_oe_r |-> addr_q inside {8'h0b, 8'h0c,
		8'h0d}) else $error("drive unmapped");
	AST_RD_CAUSE: assert property (ad_oe_r |-> $past(!cs_b && read_not_write))
		else $error("drive without read");
	AST_SQW: assert property (square_wave_out_r |-> $past(square_src))
		else $error("square out");
	AST_DST_CAUSE: assert property (dst_load_r |-> $past(sec_advance))
		else $error("dst cause");
	AST_DST_HOUR: assert property (dst_load_r |-> dst_hour_r == 8'h01 ||
		dst_hour_r == 8'h03) else $error("dst hour");
	AST_DST_PULSE: assert property (dst_load_r |=> !dst_load_r)
		else $error("dst twice");
endmodule
bind rtccs_ctrl rtccs_ctrl_chk u_chk (.core_clk, .rst_b, .cs_b, .addr_strobe,
	.read_not_write, .ad_in, .ad_out_r, .ad_oe_r, .update_done, .alarm_match,
	.periodic_tick, .square_src, .backup_ok, .sec_advance, .dst_load_r,
	.dst_hour_r, .square_wave_out_r, .irq_b_r);
`default_nettype wire

// file: test_rtc_control_status_flags.sv
/* bench for rtccs_ctrl; host model on the bus, read data checked by queue */
`timescale 1ns/1ps
`default_nettype none
module test_rtc_control_status_flags;
	logic       core_clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       cs_b, addr_strobe, data_strobe, read_not_write, ad_oe_r;
	logic       hfs, nfs, te, dl, square_wave_out, irq_b, oe_q = 1'b0;
	logic       square_src = 1'b0, backup_ok = 1'b1, sec_adv = 1'b0;
	logic [2:0] ev_v = 3'h0;
	logic [7:0] ad_in, ad_out_r, dst_h, v;
	logic [7:0] tod [0:5];
	logic [7:0] q [$];
	int         error_cnt = 0, checked = 0, dst_cnt = 0, cyc = 0;
	always #12.5 core_clk = ~core_clk;
	rtccs_host host (.core_clk(core_clk), .cs_b(cs_b), .ad_in(ad_in),
		.addr_strobe(addr_strobe), .data_strobe(data_strobe),
		.read_not_write(read_not_write));
	rtccs_ctrl DUT (.core_clk(core_clk), .rst_b(rst_b), .cs_b(cs_b),
		.addr_strobe(addr_strobe), .data_strobe(data_strobe),
		.read_not_write(read_not_write), .ad_in(ad_in), .ad_out_r(ad_out_r),
		.ad_oe_r(ad_oe_r), .update_done(ev_v[0]), .alarm_match(ev_v[1]),
		.periodic_tick(ev_v[2]), .square_src(square_src),
		.backup_ok(backup_ok), .sec_advance(sec_adv), .tod_sec(tod[0]),
		.tod_min(tod[1]), .tod_hour(tod[2]), .tod_dow(tod[3]),
		.tod_dom(tod[4]), .tod_month(tod[5]), .hour_format_select_r(hfs),
		.number_format_select_r(nfs), .transfer_enable_r(te),
		.dst_load_r(dl), .dst_hour_r(dst_h), .square_wave_out_r(square_wave_out),
		.irq_b_r(irq_b));
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task tally_and_finish;
		if (error_cnt == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task w(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		host.acc(1'b1, a, 8'h00);
	endtask
	task ev(input int i);
		ev_v <= 3'h1 << i;
		w(1);
		ev_v <= 3'h0;
		w(2);
	endtask
	task sa;
		sec_adv <= 1'b1;
		w(1);
		sec_adv <= 1'b0;
		w(3);
	endtask
	always @(posedge core_clk) begin
		oe_q <= ad_oe_r;
		cyc <= cyc + 1;
		dst_cnt <= dst_cnt + int'(dl);
		if (ad_oe_r && !oe_q) begin
			chk("read", ad_out_r, q.size() > 0 ? q.pop_front() : 8'hxx);
		end
		if (cyc == 6000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	initial begin
		void'($urandom(50006));
		tod = '{8'h3b, 8'h3b, 8'h01, 8'h01, 8'h19, 8'h0a};
		w(8);
		rst_b <= 1'b1;
		w(2);
		rd(8'h0b, 8'h00);
		rd(8'h0c, 8'h00);
		rd(8'h0d, 8'h80);
		host.acc(1'b1, 8'h0a, 8'h00);
		for (int k = 0; k < 4; k++) begin
			v = 8'($urandom) | (k == 0 ? 8'h90 : 8'h00);
			host.acc(1'b0, 8'h0b, v);
			rd(8'h0b, v[7] ? v & 8'hef : v);
			chk("fmt", {6'h00, nfs, hfs}, {6'h00, v[2:1]});
			chk("xfer", {7'h00, te}, {7'h00, ~v[7]});
		end
		for (int i = 0; i < 3; i++) begin
			host.acc(1'b0, 8'h0b, 8'h10 << i);
			ev(i);
			chk("irq", {7'h00, irq_b}, 8'h00);
			rd(8'h0c, (8'h10 << i) | 8'h80);
			w(2);
			chk("irq", {7'h00, irq_b}, 8'h01);
			rd(8'h0c, 8'h00);
		end
		// flags pend with every enable off; the host write must not touch them
		host.acc(1'b0, 8'h0b, 8'h00);
		ev(0);
		ev(1);
		ev(2);
		host.acc(1'b0, 8'h0c, 8'hff);
		chk("irq", {7'h00, irq_b}, 8'h01);
		rd(8'h0c, 8'h70);
		square_src <= 1'b1;
		host.acc(1'b0, 8'h0b, 8'h08);
		w(2);
		chk("sqw", {7'h00, square_wave_out}, 8'h01);
		host.acc(1'b0, 8'h0b, 8'h00);
		w(2);
		chk("sqw", {7'h00, square_wave_out}, 8'h00);
		backup_ok <= 1'b0;
		w(3);
		rd(8'h0d, 8'h00);
		host.acc(1'b0, 8'h0b, 8'h07);
		sa();
		sa();
		chk("fall", 8'(dst_cnt), 8'h01);
		chk("fallh", dst_h, 8'h01);
		tod[4] <= 8'h07;
		tod[5] <= 8'h04;
		sa();
		chk("spring", 8'(dst_cnt), 8'h02);
		chk("springh", dst_h, 8'h03);
		// fresh fall day, so only the cleared enable can hold the jump off
		tod[4] <= 8'h19;
		tod[5] <= 8'h0a;
		host.acc(1'b0, 8'h0b, 8'h06);
		sa();
		chk("dseoff", 8'(dst_cnt), 8'h02);
		w(4);
		tally_and_finish();
	end
endmodule
`default_nettype wire
